// [logic/sfc_defines.vh]
// Constants of the supply fault input conditioning block
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define SFC_OFF_CTRL      12'h000
`define SFC_OFF_STATUS    12'h004
`define SFC_OFF_CH_BASE   12'h040
`define SFC_OFF_CH_LAST   12'h08c
`define SFC_CH_STRIDE_LSB 3

// ****************************************
// Field positions
// ****************************************
`define SFC_CTRL_LOGIC_LSB 0
`define SFC_CTRL_EDGE_LSB  8
`define SFC_THR_UV_LSB     0
`define SFC_THR_OV_LSB     8
`define SFC_THR_HYST_LSB   16
`define SFC_THR_MODE_LSB   24
`define SFC_CFG_GLITCH_LSB 0
`define SFC_CFG_WIDTH_LSB  8
`define SFC_ST_FAULT_LSB   0
`define SFC_ST_WARN_LSB    10
`define SFC_ST_LOGIC_LSB   15
`define SFC_ST_WANY_BIT    20

// ****************************************
// Reset values and encodings
// ****************************************
`define SFC_CTRL_RST 32'h0000_0000
`define SFC_THR_RST  32'h0000_0000
`define SFC_CFG_RST  32'h0000_0000
`define SFC_MODE_UV  2'h0
`define SFC_MODE_OV  2'h1

// ****************************************
// Timing
// ****************************************
`define SFC_CLK_MHZ    50
`define SFC_MAX_US     7'h64
`define SFC_CYC_PER_US 13'h0032

`endif

// [logic/sfc_glitch.v]
// Programmable glitch filter: output follows input after it holds for a set number of cycles
`timescale 1ns/1ns
module sfc_glitch (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_ce,
  input  wire        i_in,
  input  wire [12:0] i_limit,
  output reg         o_out
);

  reg [12:0] cnt_ff;

  // ****************************************
  // Stability counter
  // ****************************************
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_out  <= 1'b0;
      cnt_ff <= 13'h0000;
    end else if (i_ce) begin
      if (i_in == o_out) begin
        cnt_ff <= 13'h0000;
      end else if (({1'b0, cnt_ff} + 14'h0001) >= {1'b0, i_limit}) begin
        o_out  <= i_in;
        cnt_ff <= 13'h0000;
      end else begin
        cnt_ff <= cnt_ff + 13'h0001;
      end
    end
  end

endmodule

// [logic/sfc_top.v]
// Supply fault input conditioning: fault detectors, warnings, aux logic inputs, APB registers
//
// Notes on behaviour
// - Each detector flags undervoltage, overvoltage or out-of-window against its limits.
// - Thresholds are 8-bit codes, linear steps of one 255th of range.
// - Hysteresis applies only once a fault is asserted.
// - Undervoltage clears only at threshold plus hysteresis or above.
// - Overvoltage clears only at threshold minus hysteresis or below.
// - Hysteresis code is 5 bits, at most 31, in 255ths of range.
// - Every detector output has a glitch filter programmable 0 to 100 us.
// - Pulses shorter than the timeout never reach the filter output.
// - Longer pulses pass, delayed by exactly the timeout.
// - Each aux input is either a low-range detector or a logic input.
// - Aux in logic mode makes its detector a warning on the mapped primary.
// - Warning detectors share the primary's range and give warnings, not faults.
// - Warnings are readable in status and ORed into one warning output.
// - Five aux logic inputs feed sequencing, each level or edge mode.
// - Level mode outputs a buffered copy of the filtered level.
// - Edge mode emits one pulse of programmable width 0 to 100 us per transition.
// - Logic inputs use the same programmable glitch filter.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "sfc_defines.vh"
module sfc_top (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_ce,
  input  wire [79:0] i_code,
  input  wire [4:0]  i_aux_pin,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  output reg  [9:0]  o_fault,
  output reg  [4:0]  o_warn,
  output reg         o_warn_any,
  output reg  [4:0]  o_logic
);

  // ****************************************
  // Helpers
  // ****************************************
  function [12:0] us_to_cyc;
    input [6:0] us;
    reg   [6:0] cl;
    begin
      cl        = (us > `SFC_MAX_US) ? `SFC_MAX_US : us;
      us_to_cyc = {6'h00, cl} * `SFC_CYC_PER_US;
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg  [31:0] ctrl_ff;
  wire [31:0] thr_q [0:9];
  wire [31:0] cfg_q [0:9];
  wire [4:0]  logic_mode;
  wire [4:0]  edge_mode;
  wire        setup;
  wire        acc;
  wire        wr_en;
  wire        wr_ctrl;
  wire        in_ch;
  wire [11:0] ch_off;
  wire [3:0]  ch_idx;
  reg  [31:0] nxt_rdata;
  reg         nxt_err;

  assign logic_mode = ctrl_ff[`SFC_CTRL_LOGIC_LSB +: 5];
  assign edge_mode  = ctrl_ff[`SFC_CTRL_EDGE_LSB +: 5];
  assign setup      = i_psel & ~i_penable;
  assign acc        = i_psel & i_penable & o_pready;
  assign wr_en      = acc & i_pwrite & ~o_pslverr;
  assign wr_ctrl    = wr_en & (i_paddr == `SFC_OFF_CTRL);
  assign ch_off     = i_paddr - `SFC_OFF_CH_BASE;
  assign ch_idx     = ch_off[6:3];
  assign in_ch      = (i_paddr >= `SFC_OFF_CH_BASE) && (i_paddr <= `SFC_OFF_CH_LAST) &&
                      (i_paddr[1:0] == 2'h0);

  // ****************************************
  // APB read decode
  // ****************************************
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    if (i_paddr == `SFC_OFF_CTRL) begin
      nxt_rdata = ctrl_ff;
    end else if (i_paddr == `SFC_OFF_STATUS) begin
      nxt_rdata[`SFC_ST_FAULT_LSB +: 10] = o_fault;
      nxt_rdata[`SFC_ST_WARN_LSB +: 5]   = o_warn;
      nxt_rdata[`SFC_ST_LOGIC_LSB +: 5]  = o_logic;
      nxt_rdata[`SFC_ST_WANY_BIT]        = o_warn_any;
    end else if (in_ch) begin
      nxt_rdata = ch_off[2] ? cfg_q[ch_idx] : thr_q[ch_idx];
    end else begin
      nxt_err = 1'b1;
    end
  end

  // ****************************************
  // APB handshake, one access cycle
  // ****************************************
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready <= setup;
      if (setup) begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : nxt_rdata;
        o_pslverr <= nxt_err;
      end else begin
        o_prdata  <= 32'h0000_0000;
        o_pslverr <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_ff <= `SFC_CTRL_RST;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        ctrl_ff <= i_pwdata & 32'h0000_1f1f;
      end
    end
  end

  // ****************************************
  // Per-channel fault detectors
  // ****************************************
  wire [9:0] raw_flt;
  wire [9:0] filt;

  genvar ch;
  generate
    for (ch = 0; ch < 10; ch = ch + 1) begin : g_ch
      // Aux n maps onto primary n, the fifth aux onto high voltage
      localparam integer pri_ch = (ch < 5) ? ch : ch - 5;
      reg  [31:0] thr_ff;
      reg  [31:0] cfg_ff;
      reg  [7:0]  src;
      reg         uv_ff;
      reg         ov_ff;
      wire        wr_thr;
      wire        wr_cfg;
      wire [7:0]  uv_th;
      wire [7:0]  ov_th;
      wire [4:0]  hyst;
      wire [1:0]  mode;
      wire [8:0]  uv_clr;
      wire [8:0]  ov_clr;
      wire        nxt_uv;
      wire        nxt_ov;
      wire        uv_on;
      wire        ov_on;
      wire [12:0] flt_lim;

      // ****************************************
      // Channel limit and filter registers
      // ****************************************
      assign wr_thr    = wr_en && in_ch && (ch_idx == ch) && !ch_off[2];
      assign wr_cfg    = wr_en && in_ch && (ch_idx == ch) && ch_off[2];
      assign thr_q[ch] = thr_ff;
      assign cfg_q[ch] = cfg_ff;

      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          thr_ff <= `SFC_THR_RST;
          cfg_ff <= `SFC_CFG_RST;
        end else if (i_ce) begin
          if (wr_thr) begin
            thr_ff <= i_pwdata & 32'h031f_ffff;
          end
          if (wr_cfg) begin
            cfg_ff <= i_pwdata & 32'h0000_7f7f;
          end
        end
      end

      // Aux detector watches its mapped primary code in logic mode
      always @* begin
        if ((ch >= 5) && logic_mode[pri_ch]) begin
          src = i_code[pri_ch*8 +: 8];
        end else begin
          src = i_code[ch*8 +: 8];
        end
      end

      assign uv_th  = thr_ff[`SFC_THR_UV_LSB +: 8];
      assign ov_th  = thr_ff[`SFC_THR_OV_LSB +: 8];
      assign hyst   = thr_ff[`SFC_THR_HYST_LSB +: 5];
      assign mode   = thr_ff[`SFC_THR_MODE_LSB +: 2];
      assign uv_clr = {1'b0, uv_th} + {4'h0, hyst};
      assign ov_clr = {1'b0, src} + {4'h0, hyst};
      // Plain threshold sets, hysteresis only on release
      assign nxt_uv = uv_ff ? ({1'b0, src} < uv_clr) : (src < uv_th);
      assign nxt_ov = ov_ff ? (ov_clr > {1'b0, ov_th}) : (src > ov_th);

      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          uv_ff <= 1'b0;
          ov_ff <= 1'b0;
        end else if (i_ce) begin
          uv_ff <= nxt_uv;
          ov_ff <= nxt_ov;
        end
      end

      // Window mode watches both limits
      assign uv_on       = (mode != `SFC_MODE_OV);
      assign ov_on       = (mode != `SFC_MODE_UV);
      assign raw_flt[ch] = (uv_on & uv_ff) | (ov_on & ov_ff);
      assign flt_lim     = us_to_cyc(cfg_ff[`SFC_CFG_GLITCH_LSB +: 7]);

      sfc_glitch u_flt (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_in    (raw_flt[ch]),
        .i_limit (flt_lim),
        .o_out   (filt[ch])
      );
    end
  endgenerate

  // ****************************************
  // Aux logic inputs
  // ****************************************
  wire [4:0] lgc;

  genvar a;
  generate
    for (a = 0; a < 5; a = a + 1) begin : g_aux
      reg         s1_ff;
      reg         s2_ff;
      reg         s3_ff;
      reg         lvl_ff;
      reg         prev_ff;
      reg         pls_ff;
      reg  [12:0] pcnt_ff;
      wire        lf;
      wire        lf_edge;
      wire [12:0] glim;
      wire [12:0] wcyc;

      // Change counts once second and third stage agree
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          s1_ff  <= 1'b0;
          s2_ff  <= 1'b0;
          s3_ff  <= 1'b0;
          lvl_ff <= 1'b0;
        end else if (i_ce) begin
          s1_ff <= i_aux_pin[a];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
          end
        end
      end

      assign glim = us_to_cyc(cfg_q[a+5][`SFC_CFG_GLITCH_LSB +: 7]);

      sfc_glitch u_lgf (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_in    (lvl_ff),
        .i_limit (glim),
        .o_out   (lf)
      );

      assign wcyc    = us_to_cyc(cfg_q[a+5][`SFC_CFG_WIDTH_LSB +: 7]);
      assign lf_edge = lf ^ prev_ff;

      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          prev_ff <= 1'b0;
          pls_ff  <= 1'b0;
          pcnt_ff <= 13'h0000;
        end else if (i_ce) begin
          prev_ff <= lf;
          if (lf_edge && (wcyc != 13'h0000)) begin
            pls_ff  <= 1'b1;
            pcnt_ff <= wcyc - 13'h0001;
          end else if (pcnt_ff != 13'h0000) begin
            pls_ff  <= 1'b1;
            pcnt_ff <= pcnt_ff - 13'h0001;
          end else begin
            pls_ff <= 1'b0;
          end
        end
      end

      assign lgc[a] = edge_mode[a] ? pls_ff : lf;
    end
  endgenerate

  // ****************************************
  // Output registers
  // ****************************************
  reg [9:0] nxt_fault;
  reg [4:0] nxt_warn;
  reg [4:0] nxt_logic;

  always @* begin
    nxt_fault       = filt;
    nxt_fault[9:5]  = filt[9:5] & ~logic_mode;
    nxt_warn        = filt[9:5] & logic_mode;
    nxt_logic       = lgc & logic_mode;
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fault    <= 10'h000;
      o_warn     <= 5'h00;
      o_warn_any <= 1'b0;
      o_logic    <= 5'h00;
    end else if (i_ce) begin
      o_fault    <= nxt_fault;
      o_warn     <= nxt_warn;
      o_warn_any <= |nxt_warn;
      o_logic    <= nxt_logic;
    end
  end

endmodule

// [verif/sfc_properties.sv]
// Port-level checks of the supply fault conditioning block
`timescale 1ns/1ns
module sfc_properties (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_ce,
  input wire [79:0] i_code,
  input wire [4:0]  i_aux_pin,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire [9:0]  o_fault,
  input wire [4:0]  o_warn,
  input wire        o_warn_any,
  input wire [4:0]  o_logic
);
  // ****************
  // Channel 0 limits
  // ****************
  reg  [31:0] thr0_ff;
  wire [8:0]  clr0 = {1'h0, thr0_ff[7:0]} + {4'h0, thr0_ff[20:16]};
  wire        uv0  = thr0_ff[25:24] == 2'h0;
  wire [8:0]  c0   = {1'h0, i_code[7:0]};
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      thr0_ff <= 32'h0;
    end else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == 12'h040) begin
      thr0_ff <= i_pwdata;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_ready_after_setup: assert property (i_ce && i_psel && !i_penable |=> o_pready)
    else $error("pready missing");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("pready held");
  a_rdata_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0) else $error("prdata not zero");
  a_slverr_with_ready: assert property (o_pslverr |-> o_pready) else $error("pslverr alone");
  a_warn_any_set: assert property ((o_warn != 5'h00) [*2] |-> o_warn_any)
    else $error("warn_any low");
  a_warn_any_clear: assert property ((o_warn == 5'h00) [*2] |-> !o_warn_any)
    else $error("warn_any high");
  a_uv_set: assert property (uv0 && $past(c0, 3) < {1'h0, thr0_ff[7:0]} |-> o_fault[0])
    else $error("uv fault not set");
  a_uv_hold: assert property (uv0 && o_fault[0] && $past(c0, 2) < clr0 |=> o_fault[0])
    else $error("uv fault cleared early");
  a_uv_clear: assert property (uv0 && o_fault[0] && $past(c0, 2) >= clr0 |=> !o_fault[0])
    else $error("uv fault stuck");
  cover property (o_pslverr);
  cover property ($rose(o_fault[0]));
  cover property ($rose(o_logic[0]));
  cover property (o_warn_any);
endmodule
bind sfc_top sfc_properties sfc_properties_i (.*);

// [verif/sfc_partner.sv]
// Comparator codes and board logic pins feeding the block
`timescale 1ns/1ns
module sfc_partner (
  input  wire         i_clk,
  output logic [79:0] o_code,
  output logic [4:0]  o_aux_pin
);
  // ****************
  // Stimulus
  // ****************
  // No ADC round-robin here, so channel 0 may keep a zero filter
  initial begin
    o_code = {10{8'hc0}};
    o_aux_pin = 5'h00;
  end
  task automatic set_code(input int ch, input logic [7:0] v);
    @(posedge i_clk);
    o_code[ch*8 +: 8] <= v;
  endtask
  task automatic set_pin(input int n, input logic v);
    @(posedge i_clk);
    o_aux_pin[n] <= v;
  endtask
endmodule

// [verif/test_sfc_top.sv]
// Self-checking testbench of the supply fault conditioning block
`timescale 1ns/1ns
module test_sfc_top;
  logic        i_clk = 1'h0;
  logic        i_rst = 1'h1;
  logic        i_ce = 1'h1;
  logic        i_psel = 1'h0;
  logic        i_penable = 1'h0;
  logic        i_pwrite = 1'h0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  wire  [79:0] i_code;
  wire  [4:0]  i_aux_pin;
  wire  [31:0] o_prdata;
  wire         o_pready;
  wire         o_pslverr;
  wire  [9:0]  o_fault;
  wire  [4:0]  o_warn;
  wire         o_warn_any;
  wire  [4:0]  o_logic;
  logic [31:0] rd;
  logic        er;
  int          mismatches = 0;
  int          n_compared = 0;
  int          c;
  int          d;
  sfc_top sfc_top_i (.*);
  sfc_partner sfc_partner_i (.i_clk(i_clk), .o_code(i_code), .o_aux_pin(i_aux_pin));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
    @(posedge i_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= dt;
    @(posedge i_clk);
    i_penable <= 1'h1;
    @(posedge i_clk);
    while (o_pready !== 1'h1) begin
      @(posedge i_clk);
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic waitn(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic code_is(input int ch, input logic [7:0] v, input int b, input logic e);
    sfc_partner_i.set_code(ch, v);
    waitn(4);
    chk("fault", 32'(e), 32'(o_fault[b]));
  endtask
  // Cycles with aux logic 0 high, or channel 2 fault high
  task automatic count(input int n, input logic lg, output int k);
    k = 0;
    repeat (n) begin
      @(negedge i_clk);
      if ((lg ? o_logic[0] : o_fault[2]) === 1'h1) k++;
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    apb(1'h0, 12'h000, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'h1, 12'h040, 32'h0004_0080);
    apb(1'h0, 12'h040, 32'h0);
    chk("thr0", 32'h0004_0080, rd);
    apb(1'h1, 12'h004, 32'hffff_ffff);
    apb(1'h0, 12'h004, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'h0, 12'h100, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    $display("test regs done");
  endtask
  task automatic t_levels;
    code_is(0, 8'h80, 0, 1'h0);
    code_is(0, 8'h7f, 0, 1'h1);
    code_is(0, 8'h83, 0, 1'h1);
    code_is(0, 8'h84, 0, 1'h0);
    sfc_partner_i.set_code(3, 8'h50);
    apb(1'h1, 12'h048, 32'h0102_4000);
    apb(1'h1, 12'h058, 32'h0200_a040);
    code_is(1, 8'h30, 1, 1'h0);
    code_is(1, 8'h40, 1, 1'h0);
    code_is(1, 8'h41, 1, 1'h1);
    code_is(1, 8'h3f, 1, 1'h1);
    code_is(1, 8'h3e, 1, 1'h0);
    code_is(3, 8'h3f, 3, 1'h1);
    code_is(3, 8'h50, 3, 1'h0);
    code_is(3, 8'ha1, 3, 1'h1);
    code_is(3, 8'h50, 3, 1'h0);
    $display("test levels done");
  endtask
  task automatic t_glitch;
    apb(1'h1, 12'h050, 32'h0000_0080);
    apb(1'h1, 12'h054, 32'h0000_0001);
    sfc_partner_i.set_code(2, 8'h10);
    count(29, 1'h0, c);
    sfc_partner_i.set_code(2, 8'hc0);
    count(80, 1'h0, d);
    chk("short pulse", 32'h0, 32'(c + d));
    sfc_partner_i.set_code(2, 8'h10);
    waitn(51);
    chk("before timeout", 32'h0, 32'(o_fault[2]));
    waitn(0);
    chk("at timeout", 32'h1, 32'(o_fault[2]));
    sfc_partner_i.set_code(2, 8'hc0);
    waitn(60);
    $display("test glitch done");
  endtask
  task automatic t_aux;
    apb(1'h1, 12'h000, 32'h0000_0001);
    apb(1'h1, 12'h068, 32'h0000_0090);
    sfc_partner_i.set_code(5, 8'h10);
    waitn(4);
    chk("warn", 32'h1, 32'(o_warn));
    chk("aux fault", 32'h0, 32'(o_fault[5]));
    apb(1'h0, 12'h004, 32'h0);
    chk("status", 32'h0010_0400, rd);
    sfc_partner_i.set_code(0, 8'ha0);
    waitn(4);
    chk("warn off", 32'h0, 32'(o_warn));
    sfc_partner_i.set_pin(0, 1'h1);
    waitn(8);
    chk("level", 32'h1, 32'(o_logic));
    sfc_partner_i.set_pin(0, 1'h0);
    waitn(8);
    chk("level", 32'h0, 32'(o_logic));
    apb(1'h1, 12'h06c, 32'h0000_0100);
    apb(1'h1, 12'h000, 32'h0000_0101);
    sfc_partner_i.set_pin(0, 1'h1);
    count(80, 1'h1, c);
    chk("rise pulse", 32'd50, 32'(c));
    sfc_partner_i.set_pin(0, 1'h0);
    count(80, 1'h1, c);
    chk("fall pulse", 32'd50, 32'(c));
    apb(1'h1, 12'h06c, 32'h0000_0001);
    sfc_partner_i.set_pin(0, 1'h1);
    count(80, 1'h1, c);
    chk("zero width", 32'h0, 32'(c));
    apb(1'h1, 12'h000, 32'h0000_0001);
    sfc_partner_i.set_pin(0, 1'h0);
    count(19, 1'h1, c);
    sfc_partner_i.set_pin(0, 1'h1);
    count(80, 1'h1, d);
    chk("bounce", 32'd99, 32'(c + d));
    $display("test aux done");
  endtask
  // ****************
  // Run
  // ****************
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'h0;
    t_regs;
    t_levels;
    t_glitch;
    t_aux;
    conclude;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    conclude;
  end
endmodule
